/* logic/dci_pkg.sv */
// Shared constants, command codes and carrier types for the command pin interface.
package dci_pkg;

    // Widths of the pin groups and of the small data array.
    localparam int ADDR_W = 14;
    localparam int BANK_W = 3;
    localparam int NBANK = 8;
    localparam int DQ_W = 8;
    localparam int MEM_AW = 3;
    localparam int MEM_DW = 2 * DQ_W;

    // Command code is {select, row strobe, column strobe, write}, all active low.
    localparam logic [3:0] CMD_MODE_SET = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // Mode register selection by bank select during a mode set cycle.
    localparam logic [2:0] SEL_MODE_REG = 3'h0;
    localparam logic [2:0] SEL_EXT_MODE_REG = 3'h1;

    // Address bit positions.
    localparam int PRE_ALL_BIT = 10;
    localparam int AUTO_PRE_BIT = 10;
    localparam int EXT_TERM_EN_BIT = 2;
    localparam int EXT_DQSN_DIS_BIT = 10;
    localparam int EXT_AUX_STROBE_BIT = 11;

    // Reset values.
    localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;
    localparam logic [ADDR_W-1:0] EXT_MODE_RST = 14'h0000;

    // Command, control and address pins sampled together.
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BANK_W-1:0] bank_sel;
        logic [ADDR_W-1:0] addr;
    } dci_cmd_pins_t;

    // Power states, one-hot.
    typedef enum logic [3:0] {
        PWR_ACTIVE = 4'h1,
        PWR_PRE_PD = 4'h2,
        PWR_ACT_PD = 4'h4,
        PWR_SREF = 4'h8
    } dci_pwr_t;

    // Clock, buffer and driver enables.
    typedef struct packed {
        logic clk_run;
        logic clk_buf_en;
        logic cmd_buf_en;
        logic drv_en;
    } dci_buf_ctl_t;

endpackage

/* logic/dci_sync.sv */
// Two flip-flop level synchroniser.
`timescale 1ns/100ps
module dci_sync (
    // Destination clock
    input wire logic clk,
    // Level in and out
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic meta;
        logic stable;
    } dci_sync_st_t;

    dci_sync_st_t s_r;
    dci_sync_st_t s_nxt;

    // Only the second stage is read outside.
    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = d;
        s_nxt.stable = s_r.meta;
    end

    // No reset: this stage also carries the reset itself across.
    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign q = s_r.stable;
endmodule

/* logic/dci_mem.sv */
// Small data array with byte write enables and registered read data.
`timescale 1ns/100ps
module dci_mem (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [1:0] be,
    input wire logic [dci_pkg::MEM_AW-1:0] waddr,
    input wire logic [dci_pkg::MEM_DW-1:0] wdata,
    // Read port
    input wire logic re,
    input wire logic [dci_pkg::MEM_AW-1:0] raddr,
    output logic [dci_pkg::MEM_DW-1:0] rdata
);
    logic [dci_pkg::MEM_DW-1:0] mem_r [2**dci_pkg::MEM_AW];
    logic [dci_pkg::MEM_DW-1:0] rdata_r;

    // Each byte lane is written only if its enable is set.
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (we && be[i]) begin
                mem_r[waddr][i*dci_pkg::DQ_W +: dci_pkg::DQ_W] <= wdata[i*dci_pkg::DQ_W +: dci_pkg::DQ_W];
            end
        end
        if (re) begin
            rdata_r <= mem_r[raddr];
        end
    end

    assign rdata = rdata_r;
endmodule

/* logic/dci_top.sv */
// Command, control and data-qualifier pin behaviour of a DDR2 memory device.
//
// Notes on behaviour
// - Sample address and control on rising clock.
// - Read data timed on both clock crossings.
// - Clock gate high runs clocks, buffers, drivers.
// - Gate low: precharge/self refresh, or active down.
// - Gate synchronous except asynchronous self-refresh exit.
// - Power-down keeps only clock and gate buffers.
// - Self refresh keeps only the gate buffer.
// - Select high masks command; select is code.
// - Command from strobes, write and select.
// - Termination on data-group pins when registered high.
// - Extended mode bit can disable termination.
// - Masked write beats are not stored.
// - Mask sampled on both edges, per beat.
// - x8 mask pin is mask or read strobe.
// - Bank select names the command's bank.
// - Bank select picks mode or extended register.
// - Row on activate; column, auto-precharge on access.
// - Address bit ten low one bank, high all.
// - Single precharge closes only selected bank.
// - Mode set address carries the op code.
// - One extended bit disables complementary strobes.
`timescale 1ns/100ps
module dci_top (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link clock and command pins
    input wire logic diff_clock_pair,
    input wire logic clk_gate,
    input wire dci_pkg::dci_cmd_pins_t cmd_pins,
    input wire logic termination_ctl,
    input wire logic part_is_x8,
    // Data and mask pins
    input wire logic [dci_pkg::DQ_W-1:0] dq_i,
    output logic [dci_pkg::DQ_W-1:0] dq_rise_o,
    output logic [dci_pkg::DQ_W-1:0] dq_fall_o,
    output logic dq_oe,
    input wire logic write_mask,
    output logic read_strobe_aux_o,
    output logic read_strobe_aux_oe,
    // Status
    output dci_pkg::dci_pwr_t pwr_state,
    output dci_pkg::dci_buf_ctl_t buf_ctl,
    output logic termination_on,
    output logic dqs_compl_en,
    output logic aux_strobe_mode,
    output logic [dci_pkg::NBANK-1:0] open_banks,
    output logic [dci_pkg::ADDR_W-1:0] mode_word,
    output logic [dci_pkg::ADDR_W-1:0] ext_mode_word,
    output logic sref_active
);
    // Link-side state on the rising crossing.
    typedef struct packed {
        dci_pkg::dci_pwr_t pwr;
        dci_pkg::dci_buf_ctl_t bufc;
        logic [dci_pkg::NBANK-1:0] open_rows;
        logic [dci_pkg::ADDR_W-1:0] mode_w;
        logic [dci_pkg::ADDR_W-1:0] ext_w;
        logic [1:0] wr_pend;
        logic [1:0] rd_pend;
        logic [dci_pkg::MEM_AW-1:0] wr_idx;
        logic [dci_pkg::MEM_AW-1:0] wr_idx_d;
        logic [dci_pkg::MEM_AW-1:0] rd_idx;
        logic [dci_pkg::DQ_W-1:0] rise_dq;
        logic rise_mask;
        logic [dci_pkg::DQ_W-1:0] out_rise;
        logic [dci_pkg::DQ_W-1:0] fall_hold;
        logic oe;
        logic term_on;
        logic sr_flag;
        logic ack_seen;
    } dci_link_st_t;

    // Link-side state on the falling crossing.
    typedef struct packed {
        logic [dci_pkg::DQ_W-1:0] fall_dq;
        logic fall_mask;
        logic [dci_pkg::DQ_W-1:0] out_fall;
    } dci_neg_st_t;

    // Core-side state for the clockless self-refresh exit.
    typedef struct packed {
        logic exit_tog;
        logic exit_pend;
        logic sref;
    } dci_core_st_t;

    dci_link_st_t lr_r;
    dci_link_st_t lr_nxt;
    dci_neg_st_t ng_r;
    dci_neg_st_t ng_nxt;
    dci_core_st_t cr_r;
    dci_core_st_t cr_nxt;

    logic link_rst_n;
    logic ack_s;
    logic x8_s;
    logic sr_s;
    logic gate_s;
    logic [3:0] raw_cmd;
    logic [3:0] cmd;
    logic mem_we;
    logic [1:0] mem_be;
    logic [dci_pkg::MEM_DW-1:0] mem_rdata;

    // Command code from the four control pins.
    function automatic logic [3:0] cmd_of(input dci_pkg::dci_cmd_pins_t p);
        cmd_of = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
    endfunction

    // One-hot mask of a bank.
    function automatic logic [dci_pkg::NBANK-1:0] bank_oh(input logic [dci_pkg::BANK_W-1:0] b);
        bank_oh = '0;
        bank_oh[b] = 1'b1;
    endfunction

    // Enables that each power state leaves running.
    function automatic dci_pkg::dci_buf_ctl_t buf_of(input dci_pkg::dci_pwr_t p);
        buf_of.clk_run = (p == dci_pkg::PWR_ACTIVE);
        buf_of.drv_en = (p == dci_pkg::PWR_ACTIVE);
        buf_of.cmd_buf_en = (p == dci_pkg::PWR_ACTIVE);
        buf_of.clk_buf_en = (p != dci_pkg::PWR_SREF);
    endfunction

    // Crossings: reset, exit toggle and strap into the link; flag and gate into the core.
    dci_sync u_rst_sync (.clk(diff_clock_pair), .d(rst_n), .q(link_rst_n));
    dci_sync u_ack_sync (.clk(diff_clock_pair), .d(cr_r.exit_tog), .q(ack_s));
    dci_sync u_x8_sync (.clk(diff_clock_pair), .d(part_is_x8), .q(x8_s));
    dci_sync u_sr_sync (.clk(ref_clk), .d(lr_r.sr_flag), .q(sr_s));
    dci_sync u_gate_sync (.clk(ref_clk), .d(clk_gate), .q(gate_s));

    // Commands count only while running with the gate high; others read as a no-op.
    assign raw_cmd = cmd_of(cmd_pins);
    assign cmd = (lr_r.pwr == dci_pkg::PWR_ACTIVE && clk_gate) ? raw_cmd : dci_pkg::CMD_NOP;

    // Link next state: command decode, bank tracking, power and read/write pipes.
    always_comb begin
        lr_nxt = lr_r;
        lr_nxt.wr_pend = {lr_r.wr_pend[0], cmd == dci_pkg::CMD_WRITE};
        lr_nxt.rd_pend = {lr_r.rd_pend[0], cmd == dci_pkg::CMD_READ};
        lr_nxt.rise_dq = dq_i;
        lr_nxt.rise_mask = write_mask;
        if (lr_r.wr_pend[0]) begin
            lr_nxt.wr_idx_d = lr_r.wr_idx;
        end
        // A select held high never matches a code below, so the command is masked.
        case (cmd)
            dci_pkg::CMD_ACTIVATE: begin
                lr_nxt.open_rows = lr_r.open_rows | bank_oh(cmd_pins.bank_sel);
            end
            dci_pkg::CMD_PRECHARGE: begin
                if (cmd_pins.addr[dci_pkg::PRE_ALL_BIT]) begin
                    lr_nxt.open_rows = '0;
                end else begin
                    lr_nxt.open_rows = lr_r.open_rows & ~bank_oh(cmd_pins.bank_sel);
                end
            end
            dci_pkg::CMD_WRITE, dci_pkg::CMD_READ: begin
                // Column selects the word; auto-precharge closes the bank on the same edge as the access command.
                if (cmd == dci_pkg::CMD_WRITE) begin
                    lr_nxt.wr_idx = cmd_pins.addr[dci_pkg::MEM_AW-1:0];
                end else begin
                    lr_nxt.rd_idx = cmd_pins.addr[dci_pkg::MEM_AW-1:0];
                end
                if (cmd_pins.addr[dci_pkg::AUTO_PRE_BIT]) begin
                    lr_nxt.open_rows = lr_r.open_rows & ~bank_oh(cmd_pins.bank_sel);
                end
            end
            dci_pkg::CMD_MODE_SET: begin
                if (cmd_pins.bank_sel == dci_pkg::SEL_MODE_REG) begin
                    lr_nxt.mode_w = cmd_pins.addr;
                end else if (cmd_pins.bank_sel == dci_pkg::SEL_EXT_MODE_REG) begin
                    lr_nxt.ext_w = cmd_pins.addr;
                end
            end
            default: begin
            end
        endcase
        // Power state follows the gate on the rising crossing, except self-refresh exit.
        case (lr_r.pwr)
            dci_pkg::PWR_ACTIVE: begin
                if (!clk_gate) begin
                    if (raw_cmd == dci_pkg::CMD_REFRESH && lr_r.open_rows == '0) begin
                        lr_nxt.pwr = dci_pkg::PWR_SREF;
                        lr_nxt.sr_flag = 1'b1;
                    end else if (lr_r.open_rows != '0) begin
                        lr_nxt.pwr = dci_pkg::PWR_ACT_PD;
                    end else begin
                        lr_nxt.pwr = dci_pkg::PWR_PRE_PD;
                    end
                end
            end
            dci_pkg::PWR_PRE_PD, dci_pkg::PWR_ACT_PD: begin
                if (clk_gate) begin
                    lr_nxt.pwr = dci_pkg::PWR_ACTIVE;
                end
            end
            dci_pkg::PWR_SREF: begin
                // Exit was decided on the core clock while this clock may have stood still.
                if (ack_s != lr_r.ack_seen) begin
                    lr_nxt.ack_seen = ack_s;
                    lr_nxt.sr_flag = 1'b0;
                    lr_nxt.pwr = dci_pkg::PWR_ACTIVE;
                end
            end
            default: begin
                lr_nxt.pwr = dci_pkg::PWR_ACTIVE;
            end
        endcase
        lr_nxt.bufc = buf_of(lr_nxt.pwr);
        // Termination input is ignored unless enabled in the extended register.
        lr_nxt.term_on = (lr_r.pwr == dci_pkg::PWR_ACTIVE) && termination_ctl
            && lr_r.ext_w[dci_pkg::EXT_TERM_EN_BIT];
        // Read data goes out two crossings after the array read.
        lr_nxt.oe = lr_r.rd_pend[1];
        if (lr_r.rd_pend[1]) begin
            lr_nxt.out_rise = mem_rdata[dci_pkg::DQ_W-1:0];
            lr_nxt.fall_hold = mem_rdata[dci_pkg::MEM_DW-1:dci_pkg::DQ_W];
        end
    end

    // Falling-crossing samples of the second beat and the second half of read data.
    always_comb begin
        ng_nxt = ng_r;
        ng_nxt.fall_dq = dq_i;
        ng_nxt.fall_mask = write_mask;
        ng_nxt.out_fall = lr_r.fall_hold;
    end

    // Array write of the beat pair; in read-strobe mode the mask pin is not a mask.
    assign aux_strobe_mode = x8_s && lr_r.ext_w[dci_pkg::EXT_AUX_STROBE_BIT];
    assign mem_we = lr_r.wr_pend[1];
    assign mem_be = aux_strobe_mode ? 2'h3 : {~ng_r.fall_mask, ~lr_r.rise_mask};

    dci_mem u_mem (
        .clk(diff_clock_pair),
        .we(mem_we),
        .be(mem_be),
        .waddr(lr_r.wr_idx_d),
        .wdata({ng_r.fall_dq, lr_r.rise_dq}),
        .re(lr_r.rd_pend[0]),
        .raddr(lr_r.rd_idx),
        .rdata(mem_rdata)
    );

    // Rising-crossing link registers.
    always_ff @(posedge diff_clock_pair) begin
        if (!link_rst_n) begin
            lr_r <= '0;
            lr_r.pwr <= dci_pkg::PWR_ACTIVE;
            lr_r.bufc <= buf_of(dci_pkg::PWR_ACTIVE);
            lr_r.mode_w <= dci_pkg::MODE_RST;
            lr_r.ext_w <= dci_pkg::EXT_MODE_RST;
        end else begin
            lr_r <= lr_nxt;
        end
    end

    // Falling-crossing link registers.
    always_ff @(negedge diff_clock_pair) begin
        if (!link_rst_n) begin
            ng_r <= '0;
        end else begin
            ng_r <= ng_nxt;
        end
    end

    // Core side: gate seen high during self refresh raises one exit toggle.
    always_comb begin
        cr_nxt = cr_r;
        cr_nxt.sref = sr_s;
        if (sr_s && gate_s && !cr_r.exit_pend) begin
            cr_nxt.exit_tog = ~cr_r.exit_tog;
            cr_nxt.exit_pend = 1'b1;
        end else if (!sr_s) begin
            cr_nxt.exit_pend = 1'b0;
        end
    end

    // Core registers.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cr_r <= '0;
        end else begin
            cr_r <= cr_nxt;
        end
    end

    // Outputs, all from flip-flops except the gated aux_strobe_mode and read_strobe_aux_oe and the inverted dqs_compl_en.
    assign dq_rise_o = lr_r.out_rise;
    assign dq_fall_o = ng_r.out_fall;
    assign dq_oe = lr_r.oe;
    assign read_strobe_aux_o = lr_r.oe;
    assign read_strobe_aux_oe = lr_r.oe && aux_strobe_mode;
    assign pwr_state = lr_r.pwr;
    assign buf_ctl = lr_r.bufc;
    assign termination_on = lr_r.term_on;
    assign dqs_compl_en = !lr_r.ext_w[dci_pkg::EXT_DQSN_DIS_BIT];
    assign open_banks = lr_r.open_rows;
    assign mode_word = lr_r.mode_w;
    assign ext_mode_word = lr_r.ext_w;
    assign sref_active = cr_r.sref;

    // Checks on the link clock.
    cmd_mask_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (cmd_pins.cs_n && lr_r.pwr == dci_pkg::PWR_ACTIVE) |=> $stable(lr_r.open_rows) && $stable(lr_r.ext_w))
        else $error("Command with select high changed state.");
    act_open_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (cmd == dci_pkg::CMD_ACTIVATE) |=> lr_r.open_rows[$past(cmd_pins.bank_sel)])
        else $error("Activate did not open its bank.");
    pre_one_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (cmd == dci_pkg::CMD_PRECHARGE && !cmd_pins.addr[dci_pkg::PRE_ALL_BIT])
        |=> lr_r.open_rows == ($past(lr_r.open_rows) & ~bank_oh($past(cmd_pins.bank_sel))))
        else $error("Single-bank precharge touched another bank.");
    pre_all_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (cmd == dci_pkg::CMD_PRECHARGE && cmd_pins.addr[dci_pkg::PRE_ALL_BIT]) |=> lr_r.open_rows == '0)
        else $error("All-bank precharge left a bank open.");
    act_pd_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (lr_r.pwr == dci_pkg::PWR_ACTIVE && !clk_gate && lr_r.open_rows != '0)
        |=> lr_r.pwr == dci_pkg::PWR_ACT_PD)
        else $error("Open row did not give active power-down.");
    pd_buf_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (lr_r.pwr == dci_pkg::PWR_PRE_PD || lr_r.pwr == dci_pkg::PWR_ACT_PD)
        |-> lr_r.bufc.clk_buf_en && !lr_r.bufc.cmd_buf_en)
        else $error("Power-down buffer enables wrong.");
    sref_buf_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (lr_r.pwr == dci_pkg::PWR_SREF) |-> !lr_r.bufc.clk_buf_en && !lr_r.bufc.clk_run)
        else $error("Self refresh left the clock buffer on.");
    gate_stop_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (lr_r.pwr == dci_pkg::PWR_ACTIVE && !clk_gate) |=> !lr_r.bufc.clk_run && !lr_r.bufc.drv_en)
        else $error("Gate low did not stop clocks.");
    term_gate_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        !$past(lr_r.ext_w[dci_pkg::EXT_TERM_EN_BIT]) |-> !lr_r.term_on)
        else $error("Termination on while disabled.");
    read_lat_a: assert property (@(posedge diff_clock_pair) disable iff (!link_rst_n)
        (cmd == dci_pkg::CMD_READ) |-> ##3 dq_oe)
        else $error("Read data not driven three edges later.");

    // Check on the core clock.
    sref_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(cr_r.exit_tog) |-> $past(gate_s) && $past(sr_s))
        else $error("Self-refresh exit without gate high.");
endmodule

/* dv/dci_ctrl_model.sv */
// Controller-side model that drives the link clock, command pins and write data.
`timescale 1ns/100ps
module dci_ctrl_model (
    // Link clock and clock gate
    output logic diff_clock_pair,
    output logic clk_gate,
    // Command pins
    output dci_pkg::dci_cmd_pins_t cmd_pins,
    // Write data and mask
    output logic [dci_pkg::DQ_W-1:0] dq_i,
    output logic write_mask
);
    logic ck_run;

    // The clock runs free, as a controller's does, and is only stopped during self refresh.
    initial begin
        diff_clock_pair = 1'b0;
        ck_run = 1'b1;
        clk_gate = 1'b1;
        cmd_pins = '1;
        dq_i = 8'h00;
        write_mask = 1'b0;
        #7;
        forever begin
            #62.5;
            if (ck_run) diff_clock_pair = ~diff_clock_pair;
        end
    end

    // Pins change after a falling edge and hold across the sampling rising edge.
    task automatic cmd(input logic [3:0] code, input logic [2:0] bank, input logic [13:0] addr);
        @(negedge diff_clock_pair);
        cmd_pins = {code, bank, addr};
        @(posedge diff_clock_pair);
    endtask

    // Idle slot; released address lines show the inverse of their last value.
    task automatic nop();
        @(negedge diff_clock_pair);
        cmd_pins = {dci_pkg::CMD_NOP, ~cmd_pins.bank_sel, ~cmd_pins.addr};
    endtask

    // The gate moves here and in wake, never inside an access, so accesses keep it high.
    task automatic gate(input logic v, input logic [3:0] code);
        @(negedge diff_clock_pair);
        clk_gate = v;
        cmd_pins = {code, ~cmd_pins.bank_sel, ~cmd_pins.addr};
        @(posedge diff_clock_pair);
    endtask

    // Stopping waits for a low clock so no runt pulse reaches the device.
    task automatic clk_stop();
        @(negedge diff_clock_pair);
        ck_run = 1'b0;
    endtask

    // Restart after the asynchronous wake from self refresh.
    task automatic wake();
        clk_gate = 1'b1;
        #300;
        ck_run = 1'b1;
    endtask

    // Write burst of two beats, each beat with its own mask bit.
    task automatic wr(input logic [2:0] col, input logic [15:0] data, input logic [1:0] mask);
        cmd(dci_pkg::CMD_WRITE, 3'h0, {11'h000, col});
        nop();
        dq_i = data[7:0];
        write_mask = mask[0];
        @(posedge diff_clock_pair);
        #1;
        dq_i = data[15:8];
        write_mask = mask[1];
        @(negedge diff_clock_pair);
        #1;
        dq_i = ~data[15:8];
        write_mask = ~mask[1];
        @(posedge diff_clock_pair);
    endtask
endmodule

/* dv/dci_top_tb_top.sv */
// Self-checking testbench for the command pin interface.
`timescale 1ns/100ps
module dci_top_tb_top;
    logic ref_clk;
    logic rst_n;
    logic part_is_x8;
    logic diff_clock_pair;
    logic clk_gate;
    dci_pkg::dci_cmd_pins_t cmd_pins;
    logic termination_ctl;
    logic [7:0] dq_i;
    logic [7:0] dq_rise_o;
    logic [7:0] dq_fall_o;
    logic dq_oe;
    logic write_mask;
    logic aux_o;
    logic aux_oe;
    dci_pkg::dci_pwr_t pwr_state;
    dci_pkg::dci_buf_ctl_t buf_ctl;
    logic termination_on;
    logic dqs_compl_en;
    logic aux_strobe_mode;
    logic [7:0] open_banks;
    logic [13:0] mode_word;
    logic [13:0] ext_mode_word;
    logic sref_active;
    int bad_count;
    int n_checks;

    dci_ctrl_model u_dci_ctrl_model (.diff_clock_pair(diff_clock_pair), .clk_gate(clk_gate),
        .cmd_pins(cmd_pins), .dq_i(dq_i), .write_mask(write_mask));

    dci_top u_dci_top (.ref_clk(ref_clk), .rst_n(rst_n), .diff_clock_pair(diff_clock_pair),
        .clk_gate(clk_gate), .cmd_pins(cmd_pins), .termination_ctl(termination_ctl),
        .part_is_x8(part_is_x8), .dq_i(dq_i), .dq_rise_o(dq_rise_o), .dq_fall_o(dq_fall_o),
        .dq_oe(dq_oe), .write_mask(write_mask), .read_strobe_aux_o(aux_o), .read_strobe_aux_oe(aux_oe),
        .pwr_state(pwr_state), .buf_ctl(buf_ctl), .termination_on(termination_on),
        .dqs_compl_en(dqs_compl_en), .aux_strobe_mode(aux_strobe_mode), .open_banks(open_banks),
        .mode_word(mode_word), .ext_mode_word(ext_mode_word), .sref_active(sref_active));

    // Core clock, 50 ns period.
    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;

    // Case inequality so an unknown never passes for a match.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single closing point of the run.
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Let link edges pass, then step off the edge so register updates have landed.
    task automatic edges(input int n);
        repeat (n) @(posedge diff_clock_pair);
        #1;
    endtask

    // Bounded wait for a power state; running out ends the run.
    task automatic wait_pwr(input dci_pkg::dci_pwr_t st);
        int i;
        for (i = 0; i < 40 && pwr_state !== st; i++) @(posedge ref_clk);
        check(16'(pwr_state), 16'(st));
        if (i == 40) report_and_stop();
    endtask

    // Mode set on either register, then let the update land.
    task automatic mset(input logic [2:0] sel, input logic [13:0] op);
        u_dci_ctrl_model.cmd(dci_pkg::CMD_MODE_SET, sel, op);
        u_dci_ctrl_model.nop();
    endtask

    // Read: rise beat is checked after the second rising edge, fall beat after the next falling edge.
    task automatic rd(input logic [2:0] col, input logic [15:0] exp);
        u_dci_ctrl_model.cmd(dci_pkg::CMD_READ, 3'h0, {11'h000, col});
        u_dci_ctrl_model.nop();
        edges(2);
        check(16'(dq_oe), 16'h0001);
        check(16'(dq_rise_o), 16'(exp[7:0]));
        @(negedge diff_clock_pair);
        #1;
        check(16'(dq_fall_o), 16'(exp[15:8]));
    endtask

    // Guard against a hang anywhere in the sequence.
    initial begin
        #2000000;
        bad_count++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        part_is_x8 = 1'b1;
        termination_ctl = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        edges(4);
        check(16'(pwr_state), 16'(dci_pkg::PWR_ACTIVE));
        check(16'(buf_ctl), 16'h000f);
        check(16'(open_banks), 16'h0000);
        // Mode register selection; unassigned selects change nothing.
        mset(3'h0, 14'h0123);
        check(16'(mode_word), 16'h0123);
        mset(3'h1, 14'h0004);
        mset(3'h2, 14'h3fff);
        check(16'(ext_mode_word), 16'h0004);
        check(16'(mode_word), 16'h0123);
        check(16'(dqs_compl_en), 16'h0001);
        // Termination follows the pin only while the extended word enables it.
        @(negedge diff_clock_pair);
        termination_ctl = 1'b1;
        edges(2);
        check(16'(termination_on), 16'h0001);
        mset(3'h1, 14'h0000);
        edges(2);
        check(16'(termination_on), 16'h0000);
        mset(3'h1, 14'h0c04);
        edges(2);
        check(16'(dqs_compl_en), 16'h0000);
        check(16'(aux_strobe_mode), 16'h0001);
        mset(3'h1, 14'h0004);
        check(16'(aux_strobe_mode), 16'h0000);
        // Open every bank in turn.
        for (int b = 0; b < 8; b++) begin
            u_dci_ctrl_model.cmd(dci_pkg::CMD_ACTIVATE, b[2:0], 14'h1555);
            u_dci_ctrl_model.nop();
            check(16'(open_banks), 16'((1 << (b + 1)) - 1));
        end
        u_dci_ctrl_model.cmd(4'ha, 3'h0, 14'h0400);
        u_dci_ctrl_model.cmd(dci_pkg::CMD_PRECHARGE, 3'h3, 14'h0000);
        u_dci_ctrl_model.nop();
        check(16'(open_banks), 16'h00f7);
        // Active power-down, commands ignored inside it, synchronous exit.
        u_dci_ctrl_model.gate(1'b0, dci_pkg::CMD_NOP);
        edges(1);
        check(16'(pwr_state), 16'(dci_pkg::PWR_ACT_PD));
        check(16'(buf_ctl), 16'h0004);
        u_dci_ctrl_model.cmd(dci_pkg::CMD_PRECHARGE, 3'h0, 14'h0400);
        u_dci_ctrl_model.gate(1'b1, dci_pkg::CMD_NOP);
        edges(1);
        check(16'(pwr_state), 16'(dci_pkg::PWR_ACTIVE));
        check(16'(open_banks), 16'h00f7);
        u_dci_ctrl_model.cmd(dci_pkg::CMD_PRECHARGE, 3'h5, 14'h0400);
        u_dci_ctrl_model.nop();
        check(16'(open_banks), 16'h0000);
        u_dci_ctrl_model.gate(1'b0, dci_pkg::CMD_NOP);
        edges(1);
        check(16'(pwr_state), 16'(dci_pkg::PWR_PRE_PD));
        u_dci_ctrl_model.gate(1'b1, dci_pkg::CMD_NOP);
        // Self refresh, clock stopped, asynchronous wake.
        u_dci_ctrl_model.gate(1'b0, dci_pkg::CMD_REFRESH);
        edges(1);
        check(16'(pwr_state), 16'(dci_pkg::PWR_SREF));
        check(16'(buf_ctl), 16'h0000);
        u_dci_ctrl_model.clk_stop();
        repeat (6) @(posedge ref_clk);
        check(16'(sref_active), 16'h0001);
        @(negedge ref_clk);
        u_dci_ctrl_model.wake();
        wait_pwr(dci_pkg::PWR_ACTIVE);
        repeat (6) @(posedge ref_clk);
        check(16'(sref_active), 16'h0000);
        // Masked beats keep the stored byte.
        u_dci_ctrl_model.cmd(dci_pkg::CMD_ACTIVATE, 3'h0, 14'h0000);
        u_dci_ctrl_model.wr(3'h2, 16'h1234, 2'b00);
        u_dci_ctrl_model.wr(3'h2, 16'hccaa, 2'b10);
        u_dci_ctrl_model.wr(3'h5, 16'h5678, 2'b00);
        u_dci_ctrl_model.wr(3'h5, 16'h9abc, 2'b01);
        rd(3'h2, 16'h12aa);
        check(16'({aux_o, aux_oe}), 16'h0002);
        rd(3'h5, 16'h9a78);
        // In read-strobe mode the mask pin no longer masks, and the strobe pin drives.
        mset(3'h1, 14'h0804);
        u_dci_ctrl_model.wr(3'h2, 16'h5566, 2'b11);
        rd(3'h2, 16'h5566);
        check(16'({aux_o, aux_oe}), 16'h0003);
        edges(2);
        check(16'(dq_oe), 16'h0000);
        check(16'({aux_o, aux_oe}), 16'h0000);
        // Read-strobe mode exists only on the x8 strap.
        @(negedge diff_clock_pair);
        part_is_x8 = 1'b0;
        edges(3);
        check(16'(aux_strobe_mode), 16'h0000);
        report_and_stop();
    end
endmodule
